// ===== hdl/sdinit_pkg.sv
// Package of constants and types for the SDRAM start-up sequencer.
package sdinit_pkg;

    // Register byte offsets on the APB port.
    localparam logic [7:0] REFRESH_CTRL_OFFS = 8'h00;
    localparam logic [7:0] BANK_ADDR_CTRL_OFFS = 8'h04;
    localparam logic [7:0] BANK_MASK_OFFS = 8'h08;
    localparam logic [7:0] STATUS_OFFS = 8'h0C;

    // Field positions in the bank address/control register, and the width of the refresh count field.
    localparam int REFRESH_ENABLE_BIT = 15;
    localparam int MODE_SET_INITIATE_BIT = 6;
    localparam int PRECHARGE_INITIATE_BIT = 3;
    localparam int BASE_HI = 31;
    localparam int BASE_LO = 18;
    localparam int REFRESH_COUNT_W = 9;

    // Reset values.
    localparam logic [31:0] BANK_ADDR_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BANK_MASK_RST = 32'h0000_0000;
    localparam logic [15:0] REFRESH_CTRL_RST = 16'h0000;

    // Refresh interval is (count + 1) * 16 clocks.
    localparam int REFRESH_UNIT_CLKS = 16;

    // Command issued to the memory.
    typedef enum logic [3:0] {
        SDINIT_CMD_NOP = 4'h0,
        SDINIT_CMD_PALL = 4'h1,
        SDINIT_CMD_REF = 4'h2,
        SDINIT_CMD_MRS = 4'h3
    } sdinit_cmd_t;

    // One memory command with its address lines.
    typedef struct packed {
        logic valid;
        sdinit_cmd_t cmd;
        logic [10:0] addr;
    } sdinit_mem_cmd_t;

endpackage : sdinit_pkg

// ===== hdl/sdinit_refresh_timer.sv
// Periodic auto-refresh request generator.
`timescale 1ns/1ps
`default_nettype none
module sdinit_refresh_timer #(
    parameter int COUNT_W = 9
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Control.
    input wire logic enable,
    input wire logic [COUNT_W-1:0] count,
    // Request pulse.
    output logic tick
);
    // Refuse counter widths that the prescaled counter cannot serve.
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_count_w
        $error("COUNT_W out of range");
    end

    localparam int PRE_W = $clog2(sdinit_pkg::REFRESH_UNIT_CLKS);

    logic [PRE_W-1:0] pre_r, pre_nxt;
    logic [COUNT_W-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;

    // Prescale by sixteen, then count count+1 units; a disabled timer restarts fresh.
    always_comb begin
        pre_nxt = pre_r;
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            pre_nxt = '0;
            cnt_nxt = count;
        end else begin
            pre_nxt = PRE_W'(pre_r + 1'b1);
            if (&pre_r) begin
                if (cnt_r == '0) begin
                    cnt_nxt = count;
                    tick_nxt = 1'b1;
                end else begin
                    cnt_nxt = COUNT_W'(cnt_r - 1'b1);
                end
            end
        end
    end

    // State registers.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pre_r <= '0;
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;
endmodule : sdinit_refresh_timer
`default_nettype wire

// ===== hdl/sdinit_ctrl.sv
// SDRAM start-up sequencer: config registers, precharge, refresh, mode-set.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sdinit_ctrl (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // APB register port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host memory access request, same clock domain.
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    // Command to the memory device.
    output sdinit_pkg::sdinit_mem_cmd_t mem_cmd
);
    logic [15:0] rctl_r, rctl_nxt;
    logic [31:0] bac_r, bac_nxt;
    logic [31:0] bmask_r, bmask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic mem_ack_r, mem_ack_nxt;
    sdinit_pkg::sdinit_mem_cmd_t cmd_r, cmd_nxt;
    logic ref_pend_r, ref_pend_nxt;
    // Sticky progress flags: bit 0 precharge issued, bit 1 refresh seen, bit 2 mode set issued.
    logic [2:0] done_r, done_nxt;
    logic ref_tick;
    logic hit;
    logic [31:0] cmp_mask;
    logic apb_seen;
    logic apb_wr;
    logic access_taken;
    logic mrs_hit;
    logic pall_hit;
    logic [10:0] mode_operand;

    // Address decode: bits 31:18 outside the mask compare against the base; mask bits don't care.
    // Only bits 31:18 take part; the mode operand also uses address bits 20:18, which stay in the decode unless masked.
    assign cmp_mask = {~bmask_r[sdinit_pkg::BASE_HI:sdinit_pkg::BASE_LO],
                       {sdinit_pkg::BASE_LO{1'b0}}};
    assign hit = ((mem_addr ^ bac_r) & cmp_mask) == 32'h0000_0000;

    // The access phase is seen once and answered on the next edge. A write lands only at the
    // edge where the master samples pready high, so a dropped transfer changes nothing.
    assign apb_seen = psel && penable && !pready_r;
    assign apb_wr = psel && penable && pwrite && pready_r;

    // A host access is taken once; mem_ack blocks a second take of the same held request.
    assign access_taken = mem_req && !mem_ack_r;
    // Mode set beats precharge when software has armed both; precharge needs a write.
    assign mrs_hit = access_taken && hit && bac_r[sdinit_pkg::MODE_SET_INITIATE_BIT];
    assign pall_hit = access_taken && hit && mem_write &&
                      !bac_r[sdinit_pkg::MODE_SET_INITIATE_BIT] &&
                      bac_r[sdinit_pkg::PRECHARGE_INITIATE_BIT];

    // Mode-set operand. The latency and burst groups are wired in reverse bit order, so the
    // host must place each field bit by this table and not by plain arithmetic.
    assign mode_operand[10] = mem_addr[20];
    assign mode_operand[9] = mem_addr[19];
    assign mode_operand[8] = mem_addr[18];
    assign mode_operand[7] = mem_addr[17];
    assign mode_operand[6] = mem_addr[9];
    assign mode_operand[5] = mem_addr[10];
    assign mode_operand[4] = mem_addr[11];
    assign mode_operand[3] = mem_addr[12];
    assign mode_operand[2] = mem_addr[13];
    assign mode_operand[1] = mem_addr[14];
    assign mode_operand[0] = mem_addr[15];

    // Refresh interval counter runs only while refresh is enabled.
    sdinit_refresh_timer #(
        .COUNT_W(sdinit_pkg::REFRESH_COUNT_W)
    ) u_refresh (
        .mclk(mclk),
        .reset_n(reset_n),
        .enable(bac_r[sdinit_pkg::REFRESH_ENABLE_BIT]),
        .count(rctl_r[sdinit_pkg::REFRESH_COUNT_W-1:0]),
        .tick(ref_tick)
    );

    // Register file and APB answer.
    always_comb begin
        rctl_nxt = rctl_r;
        bac_nxt = bac_r;
        bmask_nxt = bmask_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        if (apb_seen) begin
            pready_nxt = 1'b1;
            case (paddr)
                sdinit_pkg::REFRESH_CTRL_OFFS: begin
                    prdata_nxt = {16'h0000, rctl_r};
                end
                sdinit_pkg::BANK_ADDR_CTRL_OFFS: begin
                    prdata_nxt = bac_r;
                end
                sdinit_pkg::BANK_MASK_OFFS: begin
                    prdata_nxt = bmask_r;
                end
                sdinit_pkg::STATUS_OFFS: begin
                    // Status is read-only; a write is refused and changes nothing.
                    prdata_nxt = {29'h0000_0000, done_r};
                    pslverr_nxt = pwrite;
                end
                default: begin
                    prdata_nxt = 32'h0000_0000;
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        // A special access consumes its initiate bit. This sits before the write decode so a
        // software write to this register in the same cycle wins, as software expects.
        if (mrs_hit) begin
            bac_nxt[sdinit_pkg::MODE_SET_INITIATE_BIT] = 1'b0;
        end
        if (pall_hit) begin
            bac_nxt[sdinit_pkg::PRECHARGE_INITIATE_BIT] = 1'b0;
        end
        // Software write, committed at the edge that completes the transfer.
        if (apb_wr) begin
            case (paddr)
                sdinit_pkg::REFRESH_CTRL_OFFS: begin
                    rctl_nxt = pwdata[15:0];
                end
                sdinit_pkg::BANK_ADDR_CTRL_OFFS: begin
                    bac_nxt = pwdata;
                end
                sdinit_pkg::BANK_MASK_OFFS: begin
                    bmask_nxt = pwdata;
                end
                default: begin
                    bmask_nxt = bmask_r;
                end
            endcase
        end
    end

    // Memory command issue. A refresh that falls due while a host access is taken waits one
    // cycle; it is deferred, and dropped only if refresh is disabled, so the average refresh rate is kept.
    always_comb begin
        cmd_nxt = '0;
        mem_ack_nxt = 1'b0;
        done_nxt = done_r;
        ref_pend_nxt = ref_pend_r | ref_tick;
        if (access_taken) begin
            // Ordinary reads and writes issue no command here; only the special cycles do.
            mem_ack_nxt = 1'b1;
            if (mrs_hit) begin
                cmd_nxt.valid = 1'b1;
                cmd_nxt.cmd = sdinit_pkg::SDINIT_CMD_MRS;
                cmd_nxt.addr = mode_operand;
                done_nxt[2] = 1'b1;
            end else if (pall_hit) begin
                cmd_nxt.valid = 1'b1;
                cmd_nxt.cmd = sdinit_pkg::SDINIT_CMD_PALL;
                cmd_nxt.addr = 11'h400;
                done_nxt[0] = 1'b1;
            end
        end else if (ref_pend_r) begin
            cmd_nxt.valid = 1'b1;
            cmd_nxt.cmd = sdinit_pkg::SDINIT_CMD_REF;
            ref_pend_nxt = ref_tick;
            done_nxt[1] = 1'b1;
        end
        if (!bac_r[sdinit_pkg::REFRESH_ENABLE_BIT]) begin
            ref_pend_nxt = 1'b0;
        end
    end

    // All state registers of the block.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rctl_r <= sdinit_pkg::REFRESH_CTRL_RST;
            bac_r <= sdinit_pkg::BANK_ADDR_CTRL_RST;
            bmask_r <= sdinit_pkg::BANK_MASK_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            mem_ack_r <= 1'b0;
            cmd_r <= '0;
            ref_pend_r <= 1'b0;
            done_r <= 3'h0;
        end else begin
            rctl_r <= rctl_nxt;
            bac_r <= bac_nxt;
            bmask_r <= bmask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            mem_ack_r <= mem_ack_nxt;
            cmd_r <= cmd_nxt;
            ref_pend_r <= ref_pend_nxt;
            done_r <= done_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign mem_ack = mem_ack_r;
    assign mem_cmd = cmd_r;
endmodule : sdinit_ctrl
`default_nettype wire

// ===== sim/sdinit_ctrl_asserts.sv
// Port checks for the SDRAM start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module sdinit_ctrl_asserts (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Watched ports.
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire sdinit_pkg::sdinit_mem_cmd_t mem_cmd
);
    logic [10:0] mode_map;
    // Expected mode-set operand, built from the host address.
    assign mode_map = {mem_addr[20:17], mem_addr[9], mem_addr[10], mem_addr[11],
        mem_addr[12], mem_addr[13], mem_addr[14], mem_addr[15]};
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_apb_answer: assert property (psel && penable && !pready |=> pready)
        else $error("APB access not answered");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_ack_follow: assert property (mem_req && !mem_ack |=> mem_ack)
        else $error("memory access not acknowledged");
    chk_ack_pulse: assert property (mem_ack |=> !mem_ack)
        else $error("mem_ack held too long");
    chk_mrs_mapped: assert property (
        mem_cmd.valid && mem_cmd.cmd == sdinit_pkg::SDINIT_CMD_MRS
        |-> mem_ack && mem_cmd.addr == $past(mode_map))
        else $error("mode-set address wrong");
    chk_pall_write: assert property (
        mem_cmd.valid && mem_cmd.cmd == sdinit_pkg::SDINIT_CMD_PALL
        |-> mem_ack && $past(mem_write) && mem_cmd.addr == 11'h400)
        else $error("precharge-all wrong");
    chk_ref_alone: assert property (
        mem_cmd.valid && mem_cmd.cmd == sdinit_pkg::SDINIT_CMD_REF |-> !mem_ack)
        else $error("refresh clashes with access");
endmodule : sdinit_ctrl_asserts
bind sdinit_ctrl sdinit_ctrl_asserts u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_cmd(mem_cmd));
`default_nettype wire

// ===== sim/sdinit_mem_model.sv
// Behavioural SDRAM that logs the commands it receives.
`timescale 1ns/1ps
`default_nettype none
module sdinit_mem_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset_n,
    // Command from the controller.
    input wire sdinit_pkg::sdinit_mem_cmd_t mem_cmd,
    // Log for the bench.
    output sdinit_pkg::sdinit_cmd_t last_cmd,
    output logic [10:0] last_addr,
    output logic [15:0] ref_gap,
    output logic [7:0] n_ref
);
    logic [15:0] cyc;
    logic [15:0] ref_at;
    // The gap between refreshes exposes the period the controller really uses.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {cyc, ref_at, ref_gap, n_ref, last_addr} <= '0;
            last_cmd <= sdinit_pkg::SDINIT_CMD_NOP;
        end else begin
            cyc <= cyc + 16'd1;
            if (mem_cmd.valid) begin
                last_cmd <= mem_cmd.cmd;
                last_addr <= mem_cmd.addr;
            end
            if (mem_cmd.valid && mem_cmd.cmd == sdinit_pkg::SDINIT_CMD_REF) begin
                ref_gap <= cyc - ref_at;
                ref_at <= cyc;
                n_ref <= n_ref + 8'd1;
            end
        end
    end
endmodule : sdinit_mem_model
`default_nettype wire

// ===== sim/test_sdinit_ctrl.sv
// Self-checking bench for the SDRAM start-up sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_sdinit_ctrl;
    logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, mem_addr = '0, rd;
    logic pready, pslverr, mem_req = 0, mem_write = 0, mem_ack;
    sdinit_pkg::sdinit_mem_cmd_t mem_cmd;
    sdinit_pkg::sdinit_cmd_t last_cmd;
    logic [10:0] last_addr;
    logic [15:0] ref_gap;
    logic [7:0] n_ref;
    int n_errors = 0, check_count = 0, cycles = 0;
    // A 20 MHz clock.
    always #25 mclk = ~mclk;
    sdinit_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_cmd(mem_cmd));
    sdinit_mem_model u_mem (.mclk(mclk), .reset_n(reset_n), .mem_cmd(mem_cmd),
        .last_cmd(last_cmd), .last_addr(last_addr), .ref_gap(ref_gap), .n_ref(n_ref));
    task wrap_up;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // The run needs about 1500 cycles, so this only trips on a hang.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: timeout", $time);
            wrap_up;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; an idle edge follows so psel is never set twice at once.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask : apb
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, '0);
        chk(rd, exp);
    endtask : rchk
    // Memory access held until acknowledged, dropped at that edge.
    task mem(input logic wr, input logic [31:0] a);
        mem_req <= 1;
        mem_write <= wr;
        mem_addr <= a;
        do @(posedge mclk); while (mem_ack !== 1'b1);
        mem_req <= 0;
        @(posedge mclk);
    endtask : mem
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1;
        @(posedge mclk);
        rchk(sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'h0000_0000);
        apb(1, sdinit_pkg::REFRESH_CTRL_OFFS, 32'h0000_8026);
        apb(1, sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_0300);
        apb(1, sdinit_pkg::BANK_MASK_OFFS, 32'h0074_0075);
        rchk(sdinit_pkg::REFRESH_CTRL_OFFS, 32'h0000_8026);
        rchk(sdinit_pkg::BANK_MASK_OFFS, 32'h0074_0075);
        // Unmapped and read-only places must be refused.
        apb(0, 8'h10, '0);
        chk({31'h0, e}, 32'h1);
        apb(1, sdinit_pkg::STATUS_OFFS, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        $display("Test config done");
        apb(1, sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_0308);
        mem(1, 32'hFF88_0000);
        chk(last_cmd, sdinit_pkg::SDINIT_CMD_PALL);
        rchk(sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_0300);
        chk(n_ref, 0);
        $display("Test precharge done");
        apb(1, sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_8300);
        repeat (1400) @(posedge mclk);
        chk(ref_gap, 39 * sdinit_pkg::REFRESH_UNIT_CLKS);
        $display("Test refresh done");
        // Mode set and precharge both pending: mode set must win.
        apb(1, sdinit_pkg::BANK_MASK_OFFS, 32'h007C_0075);
        apb(1, sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_8348);
        mem(1, 32'hFF88_0800);
        chk(last_cmd, sdinit_pkg::SDINIT_CMD_MRS);
        chk(last_addr, 11'h210);
        rchk(sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_8308);
        // A read and a miss must leave the armed precharge bit alone.
        mem(0, 32'hFF88_0000);
        mem(1, 32'h0000_0000);
        rchk(sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_8308);
        mem(1, 32'hFF88_0000);
        chk(last_cmd, sdinit_pkg::SDINIT_CMD_PALL);
        rchk(sdinit_pkg::BANK_ADDR_CTRL_OFFS, 32'hFF88_8300);
        rchk(sdinit_pkg::STATUS_OFFS, 32'h0000_0007);
        $display("Test mode set done");
        wrap_up;
    end
endmodule : test_sdinit_ctrl
`default_nettype wire
